// *** bench/pvp_props.sv ***
// Purpose: port-level checks for the parallel capture port
// Assumes: link clock far slower than clk
// Notes:   bound onto every instance of the port
`timescale 1ns/1ps
`default_nettype none
module pvp_props
  import pvp_pkg::*;
(
  // system
  input wire logic              clk,
  input wire logic              sys_rst,
  // register port
  input wire logic [ADDR_W-1:0] reg_addr,
  input wire logic              reg_rd,
  input wire logic [15:0]       reg_rdata,
  // link and stream
  input wire logic              port_input_clock,
  input wire logic [2:0]        fs_oe,
  input wire logic [DATA_W-1:0] pd_oe,
  input wire logic              rx_valid,
  input wire logic              tx_take
);
  default clocking @(posedge clk); endclocking
  default disable iff (sys_rst);
  property p_rd_unmapped;
    reg_rd && reg_addr > 4'h5 |=> reg_rdata == 16'h0000;
  endproperty
  a_rd_unmapped: assert property (p_rd_unmapped) else $error("unmapped read not zero");
  property p_rd_hold;
    !reg_rd |=> $stable(reg_rdata);
  endproperty
  a_rd_hold: assert property (p_rd_hold) else $error("read data moved");
  property p_rx_pulse;
    rx_valid |=> !rx_valid;
  endproperty
  a_rx_pulse: assert property (p_rx_pulse) else $error("samples too close");
  property p_rst_quiet;
    $fell(sys_rst) |-> fs_oe == 3'h0 && pd_oe == 16'h0000 && !rx_valid;
  endproperty
  a_rst_quiet: assert property (p_rst_quiet) else $error("pins driven after reset");
  property p_half;
    pd_oe != 16'h0000 |-> !rx_valid;
  endproperty
  a_half: assert property (p_half) else $error("receive while driving");
  // a legal width is a run of ones from bit 0, at least eight long
  property p_width_mask;
    pd_oe != 16'h0000 |-> pd_oe[7:0] == 8'hff && (pd_oe & (pd_oe + 16'h0001)) == 16'h0000;
  endproperty
  a_width_mask: assert property (p_width_mask) else $error("bad data enable mask");
  property p_take_out;
    tx_take |-> pd_oe != 16'h0000;
  endproperty
  a_take_out: assert property (p_take_out) else $error("word taken while not sending");
  property p_link_cause;
    rx_valid |-> $past(port_input_clock, 3) || $past(port_input_clock, 4);
  endproperty
  a_link_cause: assert property (p_link_cause) else $error("sample without link edge");
endmodule
bind parallel_capture_port pvp_props pvp_props_inst (
  .clk(clk), .sys_rst(sys_rst), .reg_addr(reg_addr), .reg_rd(reg_rd),
  .reg_rdata(reg_rdata), .port_input_clock(port_input_clock), .fs_oe(fs_oe),
  .pd_oe(pd_oe), .rx_valid(rx_valid), .tx_take(tx_take));
`default_nettype wire

// *** bench/pvp_source.sv ***
// Purpose: converter-side source driving link clock, first sync and data
// Assumes: one word per link rising edge
// Notes:   clock stands still between frames
`timescale 1ns/1ps
`default_nettype none
module pvp_source (
  // link pins
  output logic        lclk,
  output logic        fs1,
  output logic [15:0] pd
);
  initial begin
    lclk = 1'b0;
    fs1 = 1'b0;
    pd = 16'h5a5a;
  end
  // one word per link cycle; data changes half a period before the rise
  task automatic word(input logic [15:0] v);
    pd = v;
    #80 lclk = 1'b1;
    #80 lclk = 1'b0;
  endtask
  // start off the clk grid so link edges never race the sampler
  task automatic frame(input int n, input logic [15:0] base);
    #3;
    for (int i = 0; i < n; i++) begin
      fs1 = (i == 0);
      pd = base + 16'(i);
      #80 lclk = 1'b1;
      #80 lclk = 1'b0;
    end
    fs1 = 1'b0;
    pd = ~pd;
  endtask
endmodule
`default_nettype wire

// *** bench/testbench.sv ***
// Purpose: self-checking bench for the parallel capture port
// Assumes: register port with read data one cycle late
// Notes:   expected samples queued by the driver, popped by the monitor
`timescale 1ns/1ps
`default_nettype none
module testbench;
  import pvp_pkg::*;
  logic              clk = 1'b0;
  logic              sys_rst, reg_wr, reg_rd, rx_valid, tx_take, lclk, fs1;
  logic              rd_d = 1'b0;
  logic [3:0]        reg_addr, wcode;
  logic [15:0]       reg_wdata, reg_rdata, rx_data, pd, b, pd_out, pd_oe, pd_pin;
  logic [2:0]        fs_out, fs_oe, fs_pin;
  logic [31:0]       seed = 32'd13;
  logic [15:0]       q_rx[$], q_rd[$], q_tx[$];
  int                err_total = 0, num_checks = 0, cyc = 0, d, c;
  assign fs_pin = (fs_oe & fs_out) | (~fs_oe & {2'b00, fs1});
  assign pd_pin = (pd_oe & pd_out) | (~pd_oe & pd);
  parallel_capture_port parallel_capture_port_inst (.clk(clk), .sys_rst(sys_rst),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .port_input_clock(lclk), .fs_in(fs_pin), .fs_out(fs_out),
    .fs_oe(fs_oe), .pd_in(pd_pin), .pd_out(pd_out), .pd_oe(pd_oe), .rx_data(rx_data),
    .rx_valid(rx_valid), .tx_take(tx_take));
  pvp_source pvp_source_inst (.lclk(lclk), .fs1(fs1), .pd(pd));
  always #10 clk = ~clk;
  function logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  task chk(input string nm, input logic [15:0] exp, input logic [15:0] got);
    num_checks++;
    if (got !== exp) begin
      err_total++;
      $display("wrong value %s expected %h seen %h", nm, exp, got);
    end
  endtask
  task results();
    if (err_total == 0 && num_checks > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  task wr(input logic [3:0] a, input logic [15:0] v);
    @(posedge clk);
    reg_addr <= a;
    reg_wdata <= v;
    reg_wr <= 1'b1;
    @(posedge clk);
    reg_wr <= 1'b0;
  endtask
  task rd(input logic [3:0] a, input logic [15:0] v);
    @(posedge clk);
    q_rd.push_back(v);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clk);
    reg_rd <= 1'b0;
  endtask
  task vseq(input logic [255:0] s, input int n);
    #3;
    for (int i = 0; i < n; i++) pvp_source_inst.word({8'h00, s[255 - 8 * i -: 8]});
  endtask
  always @(posedge clk) begin
    rd_d <= reg_rd;
    if (tx_take === 1'b1) begin
      if (q_tx.size() == 0) chk("tx_take", 16'h0000, 16'h0001);
      else chk("pd_out", q_tx.pop_front(), pd_out);
    end
    cyc <= cyc + 1;
    if (rx_valid === 1'b1) begin
      if (q_rx.size() == 0) chk("rx_valid", 16'h0000, 16'h0001);
      else chk("rx_data", q_rx.pop_front(), rx_data);
    end
    if (rd_d === 1'b1) chk("reg_rdata", q_rd.pop_front(), reg_rdata);
    if (cyc == 20000) begin
      err_total++;
      results();
    end
  end
  initial begin
    sys_rst = 1'b1;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    reg_addr = 4'h0;
    reg_wdata = 16'h0000;
    repeat (6) @(posedge clk);
    sys_rst <= 1'b0;
    rd(REG_CONFIG, CFG_RESET);
    rd(4'hf, 16'h0000);
    for (int f = 0; f < 4; f++) begin
      d = (f == 0) ? 0 : int'(rnd() % 4);
      c = 1 + int'(rnd() % 4);
      b = rnd();
      wr(REG_DELAY, 16'(d));
      wr(REG_COUNT, 16'(c));
      wr(REG_CONFIG, 16'h0081);
      rd(REG_DELAY, 16'(d));
      for (int k = 0; k < c; k++) q_rx.push_back(b + 16'(1 + d + k));
      // extra words after the count must be dropped
      pvp_source_inst.frame(d + c + 3, b);
      repeat (12) @(posedge clk);
      chk("rx backlog", 16'h0000, 16'(q_rx.size()));
    end
    for (int w = 0; w < 4; w++) begin
      wcode = (w == 0) ? 4'h0 : 4'(2 * w + 2);
      wr(REG_CONFIG, {5'h00, 3'b011, wcode, 4'h9});
      repeat (2) @(posedge clk);
      #1;
      chk("pd_oe", (wcode == 4'h0) ? 16'h00ff : 16'hffff >> (8 - wcode), pd_oe);
      chk("fs_oe", 16'h0003, {13'h0000, fs_oe});
    end
    wr(REG_FSCTL, 16'h0002);
    repeat (2) @(posedge clk);
    #1;
    chk("fs_out", 16'h0002, {13'h0000, fs_out});
    wr(REG_DELAY, 16'h0001);
    wr(REG_COUNT, 16'h0002);
    wr(REG_TXDATA, b);
    q_tx.push_back(b);
    q_tx.push_back(b);
    wr(REG_FSCTL, 16'h0003);
    pvp_source_inst.frame(4, b);
    repeat (12) @(posedge clk);
    chk("tx backlog", 16'h0000, 16'(q_tx.size()));
    // capture: this block drives both syncs while data comes in
    wr(REG_CONFIG, 16'h0085);
    wr(REG_FSCTL, 16'h0000);
    repeat (2) @(posedge clk);
    #1;
    chk("fs_oe capture", 16'h0003, {13'h0000, fs_oe});
    pvp_source_inst.frame(1, b);
    wr(REG_FSCTL, 16'h0003);
    q_rx.push_back(b + 16'h0002);
    q_rx.push_back(b + 16'h0003);
    pvp_source_inst.frame(4, b);
    repeat (12) @(posedge clk);
    chk("capture backlog", 16'h0000, 16'(q_rx.size()));
    // entire field: sampling starts at the field-one code, codes included
    wr(REG_CONFIG, 16'h000b);
    q_rx.push_back(16'h0080);
    q_rx.push_back(16'h0011);
    q_rx.push_back(16'h0022);
    vseq({80'hff0000f0ff0000801122, 176'h0}, 10);
    repeat (12) @(posedge clk);
    chk("field backlog", 16'h0000, 16'(q_rx.size()));
    // active only: one line counted, codes and blanking dropped
    wr(REG_CONFIG, 16'h0000);
    wr(REG_COUNT, 16'h0001);
    wr(REG_CONFIG, 16'h0003);
    q_rx.push_back(16'h0044);
    q_rx.push_back(16'h0055);
    vseq({200'hff0000f0ff00009033ff0000804455ff00009066ff00008077, 56'h0}, 25);
    repeat (12) @(posedge clk);
    chk("active backlog", 16'h0000, 16'(q_rx.size()));
    rd(REG_STATUS, 16'h0120);
    wr(REG_CONFIG, 16'h0000);
    repeat (2) @(posedge clk);
    #1;
    chk("pd_oe idle", 16'h0000, pd_oe);
    results();
  end
endmodule
`default_nettype wire

// *** rtl/parallel_capture_port.sv ***
// Purpose: parallel video / converter port, general-purpose and video modes
// Assumes: link clock at most a quarter of clk; all pins sampled by clk
// Notes:   one direction at a time; sampled words leave on a valid strobe
// Contract
// - one clock input, three syncs, sixteen data
// - link word rate at most half clk (the edge filter here needs at most a quarter of clk)
// - each sync selectable input or output
// - general mode half duplex up to sixteen bits
// - video mode moves eight or ten bits
// - decode embedded line and field preambles
// - input, frame capture, output submodes
// - incoming first sync starts data sampling
// - wait delay link cycles after sync
// - samples per sync equal transfer count
// - width eight or ten through sixteen
// - capture drives first sync horizontal, second vertical
// - output drives data and up to three syncs
// - active mode skips blanking and inter-line gaps
// - active mode drops control code words
// - after field one sync wait for start code
// - active mode count gives lines per frame
// - blanking mode passes only vertical blanking
// - field mode passes every sample
// - field mode starts right after field sync (here the xy word of the field-one code is itself the first sample)
// - logic and registers run on clk
`timescale 1ns/1ps
`default_nettype none
module parallel_capture_port
  import pvp_pkg::*;
(
  // system
  input  wire logic              clk,
  input  wire logic              sys_rst,
  // register port
  input  wire logic [ADDR_W-1:0] reg_addr,
  input  wire logic [15:0]       reg_wdata,
  input  wire logic              reg_wr,
  input  wire logic              reg_rd,
  output logic      [15:0]       reg_rdata,
  // link pins
  input  wire logic              port_input_clock,
  input  wire logic [2:0]        fs_in,
  output logic      [2:0]        fs_out,
  output logic      [2:0]        fs_oe,
  input  wire logic [DATA_W-1:0] pd_in,
  output logic      [DATA_W-1:0] pd_out,
  output logic      [DATA_W-1:0] pd_oe,
  // sample stream toward dma
  output logic      [DATA_W-1:0] rx_data,
  output logic                   rx_valid,
  output logic                   tx_take
);
  logic [15:0] cfg_q;
  logic [15:0] dly_q;
  logic [15:0] cnt_q;
  logic [15:0] txd_q;
  logic [2:0]  fsv_q;

  // three-stage sampling of all link pins; first stage read only by second
  logic [2:0]        ck_s;
  logic [2:0]        fs1_s;
  logic [2:0]        fs2_s;
  logic [2:0]        fs3_s;
  logic [DATA_W-1:0] d1_s;
  logic [DATA_W-1:0] d2_s;
  logic [DATA_W-1:0] d3_s;
  // link clock: its edges are found from stages two and three
  always_ff @(posedge clk) begin
    ck_s <= {ck_s[1:0], port_input_clock};
  end
  // syncs and data take the same three stages, so they stay aligned with
  // the detected link edge and are stable when it is acted on
  always_ff @(posedge clk) begin
    fs1_s <= fs_in;
    fs2_s <= fs1_s;
    fs3_s <= fs2_s;
  end
  always_ff @(posedge clk) begin
    d1_s <= pd_in;
    d2_s <= d1_s;
    d3_s <= d2_s;
  end
  // rising edge once stages two and three agree high after a low
  // short glitches on the link clock are filtered by that agreement
  logic lk_q;
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      lk_q <= 1'b0;
    end else if (ck_s[2] == ck_s[1]) begin
      lk_q <= ck_s[2];
    end
  end
  // relies on each link clock level lasting two clk cycles (at most a quarter of clk) so each edge is seen
  wire lk_rise = (ck_s[2] & ck_s[1]) & ~lk_q;

  // config decode
  wire       en       = cfg_q[CFG_EN];
  wire       itu      = cfg_q[CFG_ITU];
  wire [1:0] sub      = cfg_q[CFG_SUB_HI:CFG_SUB_LO];
  wire [3:0] wcode    = cfg_q[CFG_W_HI:CFG_W_LO];
  // direction bits: high means this block drives that sync pin
  wire [2:0] fs_dir   = cfg_q[CFG_FS_HI:CFG_FS_LO];
  wire       gp_in    = en & ~itu & (sub == GP_INPUT);
  wire       gp_cap   = en & ~itu & (sub == GP_CAPTURE);
  wire       gp_out   = en & ~itu & (sub == GP_OUTPUT);
  // width mask: 8 bits, or 10..16 bits; code 1 rounds up to 10, codes above 8 clamp to 16
  wire [4:0] wbits    = (wcode == W_CODE_8) ? 5'd8 :
                        (wcode < W_CODE_10) ? 5'd10 :
                        (wcode > 4'h8) ? 5'd16 : 5'(wcode) + 5'd8;
  // the shift is one bit wider than the data so that sixteen bits fit
  wire [DATA_W-1:0] wmask = DATA_W'((17'h1 << wbits) - 17'h1);
  // video: 8-bit or 10-bit samples, selected by width code
  wire [DATA_W-1:0] vmask = (wcode == W_CODE_8) ? 16'h00ff : 16'h03ff;
  // ten-bit codes are matched on their upper eight bits only
  wire [7:0] vbyte = (wcode == W_CODE_8) ? d3_s[7:0] : d3_s[9:2];

  // incoming first sync edge, counted in link clock edges
  logic fs1_q;
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      fs1_q <= 1'b0;
    end else if (lk_rise) begin
      fs1_q <= fs3_s[0];
    end
  end
  wire fs1_rise = lk_rise & fs3_s[0] & ~fs1_q & ~fs_dir[0];

  // general-purpose sequencer for input, capture and output
  gp_state_t   st_q;
  gp_state_t   st_d;
  logic [15:0] dc_q;
  logic [15:0] dc_d;
  // samples still owed in this frame
  logic [15:0] sc_q;
  logic [15:0] sc_d;
  wire         gp_run = gp_in | gp_cap | gp_out;
  // capture and output start on the frame sync this block drives
  wire         own_start = (gp_cap | gp_out) & lk_rise & fsv_q[0] & ~fs1_q;
  wire         in_start  = gp_in & fs1_rise;
  wire         start     = in_start | own_start;
  always_comb begin
    st_d = st_q;
    dc_d = dc_q;
    sc_d = sc_q;
    case (st_q)
      ST_IDLE: begin
        if (gp_run & start) begin
          dc_d = dly_q;
          sc_d = cnt_q;
          st_d = (dly_q == 16'h0000) ? ST_XFER : ST_DELAY;
        end
      end
      ST_DELAY: begin
        if (lk_rise) begin
          dc_d = dc_q - 16'h0001;
          if (dc_q == 16'h0001) begin
            st_d = ST_XFER;
          end
        end
      end
      ST_XFER: begin
        if (lk_rise) begin
          sc_d = sc_q - 16'h0001;
          if (sc_q <= 16'h0001) begin
            st_d = ST_DONE;
          end
        end
      end
      ST_DONE: begin
        // a new start is only taken from idle, one cycle later
        st_d = ST_IDLE;
      end
      default: begin
        st_d = ST_IDLE;
      end
    endcase
    // leaving the mode abandons a frame; it is never resumed
    if (!gp_run) begin
      st_d = ST_IDLE;
    end
  end
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      st_q <= ST_IDLE;
      dc_q <= 16'h0000;
      sc_q <= 16'h0000;
    end else begin
      st_q <= st_d;
      dc_q <= dc_d;
      sc_q <= sc_d;
    end
  end
  wire gp_sample = (st_q == ST_XFER) & lk_rise;

  // video preamble decoder on the upper eight bits of each sample
  logic [1:0]  pre_q;
  logic        f_q;
  logic        v_q;
  logic        h_q;
  logic        sync_q;
  logic        seen_sav_q;
  logic [15:0] lines_q;
  wire is_ff  = vbyte == TRC_FF;
  wire is_00  = vbyte == TRC_00;
  wire xy_now = itu & en & lk_rise & (pre_q == 2'h3);
  wire sav    = xy_now & ~vbyte[XY_H];
  wire eav    = xy_now &  vbyte[XY_H];
  // start of field one: a code with field bit low where the previous had it high
  wire f1_start = xy_now & ~vbyte[XY_F] & f_q;
  // an ff restarts the count except in the xy slot, so ff ff 00 00 xy still decodes
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      pre_q <= 2'h0;
    end else if (itu & en & lk_rise) begin
      if (pre_q == 2'h3) begin
        pre_q <= 2'h0;
      end else if (is_ff) begin
        pre_q <= 2'h1;
      end else if (is_00 & (pre_q != 2'h0)) begin
        pre_q <= pre_q + 2'h1;
      end else begin
        pre_q <= 2'h0;
      end
    end
  end
  always_ff @(posedge clk) begin
    if (sys_rst | ~itu | ~en) begin
      f_q        <= 1'b0;
      v_q        <= 1'b1;
      h_q        <= 1'b1;
      sync_q     <= 1'b0;
      seen_sav_q <= 1'b0;
      lines_q    <= 16'h0000;
    end else if (xy_now) begin
      f_q <= vbyte[XY_F];
      v_q <= vbyte[XY_V];
      h_q <= vbyte[XY_H];
      if (f1_start) begin
        sync_q     <= 1'b1;
        seen_sav_q <= 1'b0;
        lines_q    <= 16'h0000;
      end else if (sav & ~vbyte[XY_V] & sync_q) begin
        // once the programmed line count is reached, later lines are skipped
        if (lines_q < cnt_q) begin
          seen_sav_q <= 1'b1;
          lines_q    <= lines_q + 16'h0001;
        end else begin
          seen_sav_q <= 1'b0;
        end
      end
    end
  end
  // words of the code (ff 00 00 xy) are recognised as they arrive
  wire in_code = is_ff | (pre_q != 2'h0);
  wire act_ok  = (sub == V_ACTIVE) & sync_q & seen_sav_q & ~h_q & ~v_q
                 & ~in_code;
  wire vbi_ok  = (sub == V_VBLANK) & sync_q & v_q & ~in_code;
  wire fld_ok  = (sub == V_FIELD) & (sync_q | f1_start);
  wire v_sample = itu & en & lk_rise & (act_ok | vbi_ok | fld_ok);

  // received data toward memory; only one direction runs at a time
  wire              rx_hit  = (gp_sample & ~gp_out) | v_sample;
  wire [DATA_W-1:0] rx_mask = itu ? vmask : wmask;
  // data is refreshed every cycle; only the valid strobe marks a sample
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      rx_data  <= 16'h0000;
      rx_valid <= 1'b0;
    end else begin
      rx_valid <= rx_hit;
      rx_data  <= d3_s & rx_mask;
    end
  end
  // software must refill the word within one link cycle of this pulse
  assign tx_take = gp_sample & gp_out;

  // output pins: data only in output submode, syncs per direction bit plus the two capture syncs
  // preloaded while idle, so the first word is on the pins when a frame starts
  wire pd_load = tx_take | (gp_out & (st_q == ST_IDLE));
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      pd_out <= 16'h0000;
    end else if (pd_load) begin
      pd_out <= txd_q & wmask;
    end
  end
  assign pd_oe  = gp_out ? wmask : 16'h0000;
  // capture: fs one is hsync, fs two is vsync, all from software levels
  assign fs_out = fsv_q;
  // capture always drives hsync and vsync whatever the direction bits say
  wire [2:0] cap_fs = {1'b0, gp_cap, gp_cap};
  assign fs_oe  = fs_dir | cap_fs;

  // register port
  wire wr_cfg = reg_wr & (reg_addr == REG_CONFIG);
  wire wr_dly = reg_wr & (reg_addr == REG_DELAY);
  wire wr_cnt = reg_wr & (reg_addr == REG_COUNT);
  wire wr_txd = reg_wr & (reg_addr == REG_TXDATA);
  wire wr_fsv = reg_wr & (reg_addr == REG_FSCTL);
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      cfg_q <= CFG_RESET;
      dly_q <= 16'h0000;
      cnt_q <= 16'h0000;
      txd_q <= 16'h0000;
      fsv_q <= 3'h0;
    end else begin
      if (wr_cfg) begin
        cfg_q <= reg_wdata;
      end
      if (wr_dly) begin
        dly_q <= reg_wdata;
      end
      if (wr_cnt) begin
        cnt_q <= reg_wdata;
      end
      if (wr_txd) begin
        txd_q <= reg_wdata;
      end
      if (wr_fsv) begin
        fsv_q <= reg_wdata[2:0];
      end
    end
  end
  // only the low eight bits of the line counter fit beside the flags
  wire [7:0]  line_lo = lines_q[7:0];
  wire [5:0]  flags   = {2'b00, sync_q, f_q, v_q, h_q};
  wire [15:0] status  = {line_lo, flags, st_q[3:2]};
  // unmapped offsets read as zero
  wire [15:0] rd_mux = (reg_addr == REG_CONFIG) ? cfg_q :
                       (reg_addr == REG_DELAY)  ? dly_q :
                       (reg_addr == REG_COUNT)  ? cnt_q :
                       (reg_addr == REG_STATUS) ? status :
                       (reg_addr == REG_TXDATA) ? txd_q :
                       (reg_addr == REG_FSCTL)  ? {13'h0000, fsv_q} : 16'h0000;
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      reg_rdata <= 16'h0000;
    end else if (reg_rd) begin
      reg_rdata <= rd_mux;
    end
  end
endmodule
`default_nettype wire

// *** rtl/pvp_pkg.sv ***
// Purpose: shared constants for the parallel video port
// Assumes: 50 MHz system clock, link clock sampled as a plain input
// Notes:   register indices are word offsets on the simple register port
package pvp_pkg;
  localparam int          DATA_W       = 16;
  localparam int          ADDR_W       = 4;
  localparam logic [3:0]  REG_CONFIG   = 4'h0;
  localparam logic [3:0]  REG_DELAY    = 4'h1;
  localparam logic [3:0]  REG_COUNT    = 4'h2;
  localparam logic [3:0]  REG_STATUS   = 4'h3;
  localparam logic [3:0]  REG_TXDATA   = 4'h4;
  localparam logic [3:0]  REG_FSCTL    = 4'h5;
  // config fields
  localparam int          CFG_EN       = 0;
  localparam int          CFG_ITU      = 1;
  localparam int          CFG_SUB_LO   = 2;
  localparam int          CFG_SUB_HI   = 3;
  localparam int          CFG_W_LO     = 4;
  localparam int          CFG_W_HI     = 7;
  localparam int          CFG_FS_LO    = 8;
  localparam int          CFG_FS_HI    = 10;
  localparam logic [15:0] CFG_RESET    = 16'h0000;
  // general-purpose submodes
  localparam logic [1:0]  GP_INPUT     = 2'h0;
  localparam logic [1:0]  GP_CAPTURE   = 2'h1;
  localparam logic [1:0]  GP_OUTPUT    = 2'h2;
  // video submodes
  localparam logic [1:0]  V_ACTIVE     = 2'h0;
  localparam logic [1:0]  V_VBLANK     = 2'h1;
  localparam logic [1:0]  V_FIELD      = 2'h2;
  // width codes: 0 means 8 bits, 2..8 means 10..16 bits
  localparam logic [3:0]  W_CODE_8     = 4'h0;
  localparam logic [3:0]  W_CODE_10    = 4'h2;
  // video timing reference code
  localparam logic [7:0]  TRC_FF       = 8'hff;
  localparam logic [7:0]  TRC_00       = 8'h00;
  localparam int          XY_F         = 6;
  localparam int          XY_V         = 5;
  localparam int          XY_H         = 4;
  typedef enum logic [3:0] {
    ST_IDLE  = 4'b0001,
    ST_DELAY = 4'b0010,
    ST_XFER  = 4'b0100,
    ST_DONE  = 4'b1000
  } gp_state_t;
endpackage
